// [logic/aic_top.sv]
// Command byte, alarm compare, watchdog and interrupt pins.
// Assumes the counting chain sits on CLK and gives a 100 Hz
// tick, a seconds-rollover pulse and the current time.
// Operation
// - Mask bits pick minute, match levels
// - Command byte decoded at offset 0x0B
// - Refresh bit low freezes clock copies
// - Swap bit routes alarms to A/B
// - Sense bit picks B source or sink
// - Pulse bit picks level or pulse
// - Pulse lasts at least 3 ms unless an access to its registers clears the flag first
// - Watchdog mask gates watchdog interrupt
// - Alarm mask gates alarm interrupt
// - Watchdog flag set by hardware, read-only
// - Watchdog register access clears watchdog flag
// - Alarm flag set by hardware, read-only
// - Alarm register access clears alarm flag
// - Pulse mode flag tracks the pulse
// - BCD watchdog countdown, reload, repeat
// - Zero interval disables the watchdog
// - Compare time; minute mode on rollover
`timescale 1ns/1ps
`include "aic_regs.svh"
module aic_top
  import aic_pkg::*;
#(
  parameter int PULSE_CYC = `AIC_IPW_CYC
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [`AIC_ADDR_W-1:0] ADDR,
  input wire logic CE_N,
  input wire logic OE_N,
  input wire logic WE_N,
  input wire logic [7:0] DQ_I,
  output logic [7:0] DQ_O,
  output logic DQ_OE,
  input wire logic TICK_100HZ,
  input wire logic SEC_ROLL,
  input wire logic [7:0] CUR_MIN,
  input wire logic [7:0] CUR_HOUR,
  input wire logic [7:0] CUR_DAY,
  output logic COPY_REFRESH_ON,
  output logic IRQ_OUT_A_O,
  output logic IRQ_OUT_A_OE,
  output logic IRQ_OUT_B_O,
  output logic IRQ_OUT_B_OE
);

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic is_al(input logic [`AIC_ADDR_W-1:0] a);
    return a == `AIC_OFF_AL_MIN || a == `AIC_OFF_AL_HOUR ||
      a == `AIC_OFF_AL_DAY;
  endfunction : is_al

  function automatic logic is_wd(input logic [`AIC_ADDR_W-1:0] a);
    return a == `AIC_OFF_WD_LO || a == `AIC_OFF_WD_HI;
  endfunction : is_wd

  function automatic logic [13:0] bcd2bin(input logic [15:0] b);
    return 14'(b[15:12] * 1000 + b[11:8] * 100 + b[7:4] * 10 +
      b[3:0]);
  endfunction : bcd2bin

  // Undefined mask mixes raise no alarm at all
  // Current time comes in as arguments so that a continuous
  // assignment calling this re-evaluates when the time moves
  function automatic logic tod_match(
    input logic [7:0] amin,
    input logic [7:0] ahour,
    input logic [7:0] aday,
    input logic [7:0] cmin,
    input logic [7:0] chour,
    input logic [7:0] cday
  );
    logic m;
    logic h;
    logic d;
    m = cmin[6:0] == amin[6:0];
    h = chour[6:0] == ahour[6:0];
    d = cday[2:0] == aday[2:0];
    case ({amin[7], ahour[7], aday[7]})
      3'h7: return 1'b1;
      3'h3: return m;
      3'h1: return m && h;
      3'h0: return m && h && d;
      default: return 1'b0;
    endcase
  endfunction : tod_match

  aic_state_t s;
  aic_state_t next_s;
  logic wr_act;
  logic rd_act;
  logic wr_commit;
  logic rd_start;
  logic [1:0] acc;
  logic [1:0] evt;
  logic [1:0] req;
  logic [13:0] wd_val;

  // ****************************************
  // Bus strobes and events
  // ****************************************
  // Write lands on the trailing edge, when data is settled
  assign wr_act = !s.s2.ce_n && !s.s2.we_n;
  assign rd_act = !s.s2.ce_n && !s.s2.oe_n && s.s2.we_n;
  assign wr_commit = s.wr_prev && !wr_act;
  assign rd_start = rd_act && !s.rd_prev;
  assign acc[0] = (wr_commit && is_al(s.lat_addr)) ||
    (rd_start && is_al(s.s2.addr));
  assign acc[1] = (wr_commit && is_wd(s.lat_addr)) ||
    (rd_start && is_wd(s.s2.addr));
  assign wd_val = bcd2bin({s.wd_hi, s.wd_lo});
  // Index 0 is the time-of-day alarm, 1 the watchdog
  assign evt[0] = SEC_ROLL && tod_match(s.al_min, s.al_hour, s.al_day,
    CUR_MIN, CUR_HOUR, CUR_DAY);
  assign evt[1] = TICK_100HZ && wd_val != '0 &&
    s.wd_cnt == 14'h0001 && !acc[1];
  // Masks gate the pins only, flags still set
  assign req[0] = s.flag[0] && !s.cmd[`AIC_B_TMASK];
  assign req[1] = s.flag[1] && !s.cmd[`AIC_B_WMASK];

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.s1 = '{ADDR, CE_N, OE_N, WE_N, DQ_I};
    next_s.s2 = s.s1;
    next_s.wr_prev = wr_act;
    next_s.rd_prev = rd_act;
    if (wr_act) begin
      next_s.lat_addr = s.s2.addr;
      next_s.lat_data = s.s2.dq;
    end
    // Register writes; flag bits of the command byte kept
    if (wr_commit) begin
      case (s.lat_addr)
        `AIC_OFF_AL_MIN: next_s.al_min = s.lat_data;
        `AIC_OFF_AL_HOUR: next_s.al_hour = s.lat_data;
        `AIC_OFF_AL_DAY: next_s.al_day = s.lat_data & `AIC_DAY_RMASK;
        `AIC_OFF_CMD: next_s.cmd[7:2] = s.lat_data[7:2];
        `AIC_OFF_WD_LO: next_s.wd_lo = s.lat_data;
        `AIC_OFF_WD_HI: next_s.wd_hi = s.lat_data;
        default: ;
      endcase
    end
    // Read data; other offsets belong to the rest of the chip
    next_s.dq_oe = 1'b0;
    next_s.dq_o = 8'h00;
    if (rd_act) begin
      next_s.dq_oe = 1'b1;
      case (s.s2.addr)
        `AIC_OFF_AL_MIN: next_s.dq_o = s.al_min;
        `AIC_OFF_AL_HOUR: next_s.dq_o = s.al_hour;
        `AIC_OFF_AL_DAY: next_s.dq_o = s.al_day;
        `AIC_OFF_CMD: next_s.dq_o = {s.cmd[7:2], s.flag[1], s.flag[0]};
        `AIC_OFF_WD_LO: next_s.dq_o = s.wd_lo;
        `AIC_OFF_WD_HI: next_s.dq_o = s.wd_hi;
        default: next_s.dq_oe = 1'b0;
      endcase
    end
    // Watchdog countdown, reloaded from the fresh value
    if (acc[1]) begin
      next_s.wd_cnt = bcd2bin({next_s.wd_hi, next_s.wd_lo});
    end else if (TICK_100HZ && wd_val != '0) begin
      if (s.wd_cnt <= 14'h0001) begin
        next_s.wd_cnt = wd_val;
      end else begin
        next_s.wd_cnt = s.wd_cnt - 14'h0001;
      end
    end
    // Flags: pulse timeout, access clear, then set wins
    for (int i = 0; i < 2; i++) begin
      if (s.cmd[`AIC_B_PULSE] && s.flag[i]) begin
        if (s.pcnt[i] == '0) begin
          next_s.flag[i] = 1'b0;
        end else begin
          next_s.pcnt[i] = s.pcnt[i] - aic_pcnt_t'(1);
        end
      end
      if (acc[i]) begin
        next_s.flag[i] = 1'b0;
      end
      if (evt[i]) begin
        next_s.flag[i] = 1'b1;
        next_s.pcnt[i] = aic_pcnt_t'(PULSE_CYC - 1);
      end
    end
    // Pin routing and drive; A is always open drain low
    next_s.irq_a_o = 1'b0;
    next_s.irq_a_oe = s.cmd[`AIC_B_SWAP] ? req[0] : req[1];
    next_s.irq_b_oe = s.cmd[`AIC_B_SWAP] ? req[1] : req[0];
    next_s.irq_b_o = s.cmd[`AIC_B_SENSE];
  end

  // ****************************************
  // State register
  // ****************************************
  // Bus idles deselected so reset makes no false write
  always_ff @(posedge CLK) begin
    if (RESET) begin
      s <= '0;
      s.s1.ce_n <= 1'b1;
      s.s2.ce_n <= 1'b1;
      s.cmd <= `AIC_CMD_RST;
    end else begin
      s <= next_s;
    end
  end

  assign DQ_O = s.dq_o;
  assign DQ_OE = s.dq_oe;
  assign COPY_REFRESH_ON = s.cmd[`AIC_B_REFRESH];
  assign IRQ_OUT_A_O = s.irq_a_o;
  assign IRQ_OUT_A_OE = s.irq_a_oe;
  assign IRQ_OUT_B_O = s.irq_b_o;
  assign IRQ_OUT_B_OE = s.irq_b_oe;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  sequence cmd_wr;
    wr_commit && s.lat_addr == `AIC_OFF_CMD;
  endsequence

  sequence wd_fire;
    TICK_100HZ && wd_val != '0 && s.wd_cnt == 14'h0001 && !acc[1];
  endsequence

  mask_decode_a: assert property (
    SEC_ROLL && s.al_min[7] && s.al_hour[7] && s.al_day[7]
    |=> s.flag[0])
    else $error("minute alarm not raised");

  cmd_write_a: assert property (
    cmd_wr |=> s.cmd[7:2] == $past(s.lat_data[7:2]))
    else $error("command byte not stored");

  copy_freeze_a: assert property (
    cmd_wr ##0 !s.lat_data[7] |=> !COPY_REFRESH_ON)
    else $error("refresh not frozen");

  irq_route_a: assert property (
    s.cmd[6] && req[0] |=> IRQ_OUT_A_OE ##0 !IRQ_OUT_A_O)
    else $error("alarm not routed to A");

  b_sense_a: assert property (
    !s.cmd[6] && req[0] && s.cmd[5] |=> IRQ_OUT_B_OE && IRQ_OUT_B_O)
    else $error("B not sourcing");

  level_hold_a: assert property (
    !s.cmd[4] && s.flag[1] && !acc[1] |=> s.flag[1])
    else $error("level flag dropped");

  pulse_start_a: assert property (
    $rose(s.flag[0]) |-> s.pcnt[0] == PULSE_CYC - 1)
    else $error("pulse length not loaded");

  pulse_end_a: assert property (
    $fell(s.flag[1]) && $past(s.cmd[4]) && !$past(acc[1])
    |-> $past(s.pcnt[1]) == 0)
    else $error("pulse flag ended early");

  wd_gate_a: assert property (
    s.cmd[3] && !req[0] |=> !IRQ_OUT_A_OE && !IRQ_OUT_B_OE)
    else $error("masked watchdog drove a pin");

  flag_ro_a: assert property (
    cmd_wr ##0 !s.flag[1] && !evt[1] |=> !s.flag[1])
    else $error("host set watchdog flag");

  wd_clear_a: assert property (
    acc[1] |=> !s.flag[1])
    else $error("watchdog flag not cleared");

  tod_clear_a: assert property (
    acc[0] && !evt[0] |=> !s.flag[0])
    else $error("alarm flag not cleared");

  wd_repeat_a: assert property (
    wd_fire |=> s.flag[1] && s.wd_cnt == $past(wd_val))
    else $error("watchdog not fired and reloaded");

  wd_off_a: assert property (
    s.wd_lo == 8'h00 && s.wd_hi == 8'h00 |-> !evt[1])
    else $error("zero watchdog fired");

  // With the alarm mask set, an alarm still raises the flag and the routed pin of the alarm is off the cycle after
  flag_mask_a: assert property (
    evt[0] && s.cmd[2] ##1 s.cmd[2] |-> s.flag[0] ##1
    !($past(s.cmd[6]) ? IRQ_OUT_A_OE : IRQ_OUT_B_OE))
    else $error("masked alarm flag wrong");

endmodule : aic_top

// [logic/aic_regs.svh]
// Offsets, field positions, reset values and timing counts.
// Assumes a 100 MHz core clock and a byte-wide host bus.
`ifndef AIC_REGS_SVH
`define AIC_REGS_SVH
// ****************************************
// Register offsets
// ****************************************
`define AIC_ADDR_W 17
`define AIC_OFF_AL_MIN 17'h0_0003
`define AIC_OFF_AL_HOUR 17'h0_0005
`define AIC_OFF_AL_DAY 17'h0_0007
`define AIC_OFF_CMD 17'h0_000B
`define AIC_OFF_WD_LO 17'h0_000C
`define AIC_OFF_WD_HI 17'h0_000D
// ****************************************
// Command byte fields
// ****************************************
`define AIC_B_REFRESH 7
`define AIC_B_SWAP 6
`define AIC_B_SENSE 5
`define AIC_B_PULSE 4
`define AIC_B_WMASK 3
`define AIC_B_TMASK 2
`define AIC_B_MASK 7
`define AIC_CMD_RST 8'h8C
`define AIC_DAY_RMASK 8'h87
// ****************************************
// Timing
// ****************************************
`define AIC_IPW_MS 3
`define AIC_CLK_KHZ 100000
`define AIC_IPW_CYC (`AIC_IPW_MS * `AIC_CLK_KHZ)
`endif

// [logic/aic_pkg.sv]
// Types shared by the alarm and interrupt control block.
// Assumes aic_regs.svh is on the include path.
`include "aic_regs.svh"
package aic_pkg;
  // ****************************************
  // Host bus sample and block state
  // ****************************************
  typedef logic [23:0] aic_pcnt_t;

  typedef struct packed {
    logic [`AIC_ADDR_W-1:0] addr;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [7:0] dq;
  } aic_bus_t;

  typedef struct packed {
    aic_bus_t s1;
    aic_bus_t s2;
    logic wr_prev;
    logic rd_prev;
    logic [`AIC_ADDR_W-1:0] lat_addr;
    logic [7:0] lat_data;
    logic [7:0] cmd;
    logic [7:0] al_min;
    logic [7:0] al_hour;
    logic [7:0] al_day;
    logic [7:0] wd_lo;
    logic [7:0] wd_hi;
    logic [13:0] wd_cnt;
    logic [1:0] flag;
    aic_pcnt_t [1:0] pcnt;
    logic [7:0] dq_o;
    logic dq_oe;
    logic irq_a_o;
    logic irq_a_oe;
    logic irq_b_o;
    logic irq_b_oe;
  } aic_state_t;
endpackage : aic_pkg

// [dv/aic_host.sv]
// Host processor model on the asynchronous byte bus.
// Assumes the block's CLK; pins move only on its falling edge.
`timescale 1ns/1ps
`include "aic_regs.svh"
module aic_host (
  input wire logic clk,
  output logic [`AIC_ADDR_W-1:0] addr,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [7:0] dq
);
  // ********************
  // Bus cycles
  // ********************
  int hold = 4; // Raised by the bench to act as a slow host
  // Deselected: data shows the inverse of its last value, not a copy
  task automatic idle(input int n);
    ce_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
    dq = ~dq;
    repeat (n) @(negedge clk);
  endtask : idle
  // Strobe held past the 2-cycle synchroniser, then released as long
  task automatic wr(input logic [`AIC_ADDR_W-1:0] a,
                    input logic [7:0] d);
    addr = a;
    dq = d;
    ce_n = 1'b0;
    we_n = 1'b0;
    repeat (hold) @(negedge clk);
    idle(hold);
  endtask : wr
  // One extra cycle so the answer is seen before release
  task automatic rd(input logic [`AIC_ADDR_W-1:0] a);
    addr = a;
    ce_n = 1'b0;
    oe_n = 1'b0;
    repeat (hold + 1) @(negedge clk);
    idle(hold);
  endtask : rd
  // Bus idle at time zero
  initial begin
    addr = '0;
    dq = 8'h00;
    idle(0);
  end
endmodule : aic_host

// [dv/tb.sv]
// Self-checking bench for the alarm and interrupt control block.
// Assumes aic_pkg, aic_top and aic_host compiled before it.
`timescale 1ns/1ps
`include "aic_regs.svh"
module tb;
  localparam int PCYC = 20;
  logic CLK, RESET, CE_N, OE_N, WE_N, TICK_100HZ, SEC_ROLL, DQ_OE;
  logic COPY_REFRESH_ON, IRQ_OUT_A_O, IRQ_OUT_A_OE, IRQ_OUT_B_O;
  logic IRQ_OUT_B_OE;
  logic [`AIC_ADDR_W-1:0] ADDR;
  logic [7:0] DQ_I, DQ_O, CUR_MIN, CUR_HOUR, CUR_DAY, am, ah, ad, exp_v;
  logic [7:0] exp_q[$];
  logic oe_q = 1'b0;
  int errors = 0;
  int samples_checked = 0;
  int n, seed;
  // ********************
  // Design, host, clock
  // ********************
  aic_top #(.PULSE_CYC(PCYC)) u_dut (
    .CLK(CLK), .RESET(RESET), .ADDR(ADDR), .CE_N(CE_N), .OE_N(OE_N),
    .WE_N(WE_N), .DQ_I(DQ_I), .DQ_O(DQ_O), .DQ_OE(DQ_OE),
    .TICK_100HZ(TICK_100HZ), .SEC_ROLL(SEC_ROLL), .CUR_MIN(CUR_MIN),
    .CUR_HOUR(CUR_HOUR), .CUR_DAY(CUR_DAY),
    .COPY_REFRESH_ON(COPY_REFRESH_ON), .IRQ_OUT_A_O(IRQ_OUT_A_O),
    .IRQ_OUT_A_OE(IRQ_OUT_A_OE), .IRQ_OUT_B_O(IRQ_OUT_B_O),
    .IRQ_OUT_B_OE(IRQ_OUT_B_OE));
  aic_host u_host (.clk(CLK), .addr(ADDR), .ce_n(CE_N), .oe_n(OE_N),
    .we_n(WE_N), .dq(DQ_I));
  // 100 MHz core clock
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // ********************
  // Checking helpers
  // ********************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Pin state as {A level, A enable, B level, B enable}
  task automatic pins(input logic [3:0] e);
    chk(8'({IRQ_OUT_A_O, IRQ_OUT_A_OE, IRQ_OUT_B_O, IRQ_OUT_B_OE}), 8'(e));
  endtask : pins
  task automatic rd(input logic [`AIC_ADDR_W-1:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.rd(a);
  endtask : rd
  // k pulses of SEC_ROLL or of the tick, then two cycles for the pins
  task automatic ev(input logic roll, input int k);
    repeat (k) begin
      @(negedge CLK);
      SEC_ROLL = roll;
      TICK_100HZ = ~roll;
      @(negedge CLK);
      SEC_ROLL = 1'b0;
      TICK_100HZ = 1'b0;
    end
    repeat (2) @(negedge CLK);
  endtask : ev
  task automatic close_out();
    if (errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  // A stray drive pops an empty queue, which then fails the compare
  always @(negedge CLK) begin
    oe_q <= DQ_OE;
    if (DQ_OE === 1'b1 && oe_q !== 1'b1) begin
      exp_v = exp_q.pop_front();
      chk(DQ_O, exp_v);
    end
  end
  // Hang guard, ten times the expected run
  initial begin
    #100_000;
    errors++;
    close_out();
  end
  // ********************
  // Scenarios
  // ********************
  initial begin
    seed = $urandom(32'h098c);
    RESET = 1'b1;
    TICK_100HZ = 1'b0;
    SEC_ROLL = 1'b0;
    CUR_MIN = 8'h00;
    CUR_HOUR = 8'h00;
    CUR_DAY = 8'h00;
    repeat (5) @(negedge CLK);
    RESET = 1'b0;
    rd(`AIC_OFF_CMD, `AIC_CMD_RST);
    u_host.wr(`AIC_OFF_CMD, 8'h7F);
    rd(`AIC_OFF_CMD, 8'h7C);
    chk(8'(COPY_REFRESH_ON), 8'h00);
    u_host.rd(17'h0_000E);
    u_host.wr(`AIC_OFF_CMD, 8'hC0);
    // Masked fields differ yet alarm; then compared fields differ
    for (int m = 0; m < 4; m++) begin
      am = {m == 0, 3'($urandom % 6), 4'($urandom % 10)};
      ah = {m < 2, 3'($urandom % 2), 4'($urandom % 10)};
      ad = {m < 3, 4'hF, 3'($urandom % 7 + 1)};
      u_host.wr(`AIC_OFF_AL_MIN, am);
      u_host.wr(`AIC_OFF_AL_HOUR, ah);
      u_host.wr(`AIC_OFF_AL_DAY, ad);
      CUR_MIN = am ^ {7'h00, am[7]};
      CUR_HOUR = ah ^ {7'h00, ah[7]};
      CUR_DAY = ad ^ {7'h00, ad[7]};
      ev(1'b1, 1);
      pins(4'h4);
      rd(`AIC_OFF_CMD, 8'hC1);
      rd(`AIC_OFF_AL_MIN, am);
      pins(4'h0);
      CUR_MIN = CUR_MIN ^ 8'h01;
      CUR_HOUR = CUR_HOUR ^ 8'h01;
      CUR_DAY = CUR_DAY ^ 8'h01;
      ev(1'b1, 1);
      rd(`AIC_OFF_CMD, {7'h60, m == 0});
      rd(`AIC_OFF_AL_DAY, ad & `AIC_DAY_RMASK);
    end
    // Unswapped pins, B sourcing, slow host, watchdog of 3 ticks
    u_host.hold = 7;
    u_host.wr(`AIC_OFF_CMD, 8'h20);
    chk(8'(COPY_REFRESH_ON), 8'h00);
    u_host.wr(`AIC_OFF_WD_LO, 8'h03);
    u_host.wr(`AIC_OFF_WD_HI, 8'h00);
    ev(1'b0, 2);
    pins(4'h2);
    ev(1'b0, 1);
    pins(4'h6);
    rd(`AIC_OFF_CMD, 8'h22);
    rd(`AIC_OFF_WD_HI, 8'h00);
    pins(4'h2);
    CUR_MIN = am;
    CUR_HOUR = ah;
    CUR_DAY = ad;
    ev(1'b1, 1);
    pins(4'h3);
    rd(`AIC_OFF_AL_HOUR, ah);
    // Both masks set: flags rise, pins stay quiet
    u_host.wr(`AIC_OFF_CMD, 8'h0C);
    ev(1'b1, 1);
    ev(1'b0, 3);
    pins(4'h0);
    rd(`AIC_OFF_CMD, 8'h0F);
    rd(`AIC_OFF_AL_MIN, am);
    rd(`AIC_OFF_WD_LO, 8'h03);
    // Pulse mode: pin width, flag only while the pulse lasts
    u_host.wr(`AIC_OFF_CMD, 8'hD0);
    chk(8'(COPY_REFRESH_ON), 8'h01);
    ev(1'b1, 1);
    n = 0;
    while (IRQ_OUT_A_OE === 1'b1 && n < 100) begin
      n++;
      @(negedge CLK);
    end
    // Pin already stood at one falling edge inside ev
    chk(8'(n + 1), 8'(PCYC));
    rd(`AIC_OFF_CMD, 8'hD0);
    ev(1'b1, 1);
    rd(`AIC_OFF_CMD, 8'hD1);
    // Zero interval keeps the watchdog silent
    u_host.wr(`AIC_OFF_WD_LO, 8'h00);
    u_host.wr(`AIC_OFF_WD_HI, 8'h00);
    ev(1'b0, 120);
    rd(`AIC_OFF_CMD, 8'hD0);
    pins(4'h0);
    chk(8'(exp_q.size()), 8'h00);
    close_out();
  end
endmodule : tb
